// ===== pkg/clk_switch_pkg.sv
// constants, register layout and timing for the cpu clock switchover control
package clk_switch_pkg;
    // register indices on the plain register port
    localparam logic [2:0] PROC_CLK_IDX = 3'h0;
    localparam logic [2:0] MAIN_MODE_IDX = 3'h1;
    localparam logic [2:0] INT_OSC_IDX = 3'h2;
    localparam logic [2:0] MAIN_OSC_IDX = 3'h3;
    localparam logic [2:0] OSC_IDX = 3'h4;
    // processor_clock_control fields
    localparam int DIV_LSB = 0;
    localparam int DIV_MSB = 2;
    localparam int CPU_SEL_BIT = 4;
    localparam int CPU_STAT_BIT = 5;
    // main_clock_mode fields
    localparam int MAIN_SEL_BIT = 0;
    localparam int MAIN_STAT_BIT = 1;
    localparam int HS_EN_BIT = 2;
    // internal_osc_mode_reg and main_osc_control_reg fields
    localparam int INT_HALT_BIT = 0;
    localparam int INT_FLAG_BIT = 7;
    localparam int MAIN_HALT_BIT = 7;
    // oscillator mode select fields
    localparam int HIGH_AMP_BIT = 0;
    localparam int SUB_START_BIT = 1;
    localparam int SUBPIN_BIT = 4;
    localparam int SUBEXT_BIT = 5;
    localparam int MAINPIN_BIT = 6;
    localparam int MAINEXT_BIT = 7;
    // reset values and divider limit
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic MAIN_HALT_RST = 1'b1;
    localparam logic [7:0] OSC_RST = 8'h00;
    localparam logic [2:0] DIV_MAX = 3'h4;
    // timing
    localparam int CLK_MHZ = 20;
    localparam int HOLD_X1_MIN_NS = 4060;
    localparam int HOLD_X1_MAX_NS = 16120;
    localparam int HOLD_X1_CYC = (HOLD_X1_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_EXT_EDGES = 160;
    localparam int SUB_SWITCH_EDGES = 2;
    localparam int MAIN_SWITCH_EDGES = 2;
    localparam int SUB_TO_MAIN_CLKS = 2;
    localparam int DIV_BASE_CLKS = 16;
    localparam int CNT_W = 9;
    // switchover sequencing
    typedef enum logic {SW_IDLE = 1'b0, SW_WAIT = 1'b1} sw_state_e;
endpackage : clk_switch_pkg

// ===== pkg/cnt_if.sv
// load, step and done signals between a switchover owner and its counter
`timescale 1ns/10ps
interface cnt_if #(parameter int W = 9);
    logic load;
    logic [W-1:0] load_val;
    logic step;
    logic busy;
    logic done;
    modport owner (output load, output load_val, output step, input busy, input done);
    modport counter (input load, input load_val, input step, output busy, output done);
endinterface : cnt_if

// ===== rtl/edge_sync.sv
// two-flop synchroniser with rising edge detector for a pin
`timescale 1ns/10ps
module edge_sync (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic pin_i,
    output logic rise_o
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else if (ce_i) begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign rise_o = ce_i & sync_r & ~last_r;
endmodule : edge_sync

// ===== rtl/switch_counter.sv
// down counter that pulses done after the loaded number of steps
`timescale 1ns/10ps
module switch_counter #(
    parameter int W = 9
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    cnt_if.counter cnt
);
    logic [W-1:0] left_r;
    logic busy_r;
    logic [W-1:0] seen_r;
    logic [W-1:0] want_r;

    // count down on each step while busy
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            left_r <= '0;
            busy_r <= 1'b0;
        end else if (ce_i) begin
            if (cnt.load) begin
                left_r <= cnt.load_val;
                busy_r <= 1'b1;
            end else if (busy_r && cnt.step) begin
                left_r <= left_r - 1'b1;
                if (left_r == 1) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end

    assign cnt.busy = busy_r;
    assign cnt.done = ce_i & busy_r & cnt.step & (left_r == 1) & ~cnt.load;

    // helper: steps taken since the last load
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seen_r <= '0;
            want_r <= '0;
        end else if (ce_i) begin
            if (cnt.load) begin
                seen_r <= '0;
                want_r <= cnt.load_val;
            end else if (busy_r && cnt.step) begin
                seen_r <= seen_r + 1'b1;
            end
        end
    end

    step_count_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        cnt.done |-> (seen_r + 1'b1) == want_r)
        else $error("counter finished after the wrong number of steps");
endmodule : switch_counter

// ===== rtl/cpu_clock_switchover_control.sv
// cpu clock source, divider and main source switchover control with oscillator stops
`timescale 1ns/10ps
module cpu_clock_switchover_control
    import clk_switch_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic cpu_tick_i,
    input wire logic int_osc_clk_i,
    input wire logic hs_clk_i,
    input wire logic sub_clk_i,
    output logic cpu_source_status_o,
    output logic [2:0] cpu_div_o,
    output logic main_source_status_o,
    output logic cpu_clk_hold_o,
    output logic int_osc_run_o,
    output logic main_osc_run_o,
    output logic sub_osc_run_o,
    output logic main_pin_mode_o,
    output logic main_external_input_mode_o,
    output logic sub_pin_mode_o,
    output logic sub_external_input_mode_o,
    output logic sub_osc_start_option_o,
    output logic main_osc_high_amplitude_o
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [2:0] main_clock_divide_select_r;
    logic cpu_source_select_r;
    logic cpu_source_status_r;
    logic [2:0] cpu_div_r;
    logic main_source_select_r;
    logic main_source_status_r;
    logic high_speed_source_enable_r;
    logic hs_en_lock_r;
    logic internal_osc_halt_r;
    logic internal_osc_state_flag_r;
    logic main_osc_halt_r;
    logic [7:0] osc_mode_r;
    logic [7:0] rdata_r;
    logic int_osc_run_r;
    logic main_osc_run_r;
    sw_state_e cpu_state_r;
    logic cpu_sub_step_r;
    logic cpu_tgt_css_r;
    logic [2:0] cpu_tgt_div_r;
    logic main_tgt_r;
    logic main_hs_step_r;
    logic hold_ext_r;
    logic int_rise;
    logic hs_rise;
    logic sub_rise;
    logic cpu_start;
    logic main_start;
    logic hold_start;
    logic [CNT_W-1:0] cpu_load_val;
    logic [7:0] rd_mux;
    logic wr_proc;
    logic wr_mode;
    logic wr_osc;

    cnt_if #(.W(CNT_W)) cpu_cnt ();
    cnt_if #(.W(CNT_W)) main_cnt ();
    cnt_if #(.W(CNT_W)) hold_cnt ();

    assign wr_proc = ce_i & wr_i & (addr_i == PROC_CLK_IDX);
    assign wr_mode = ce_i & wr_i & (addr_i == MAIN_MODE_IDX);
    assign wr_osc = ce_i & wr_i & (addr_i == OSC_IDX);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers for the oscillator clocks
    edge_sync u_int_sync (.clk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .pin_i(int_osc_clk_i), .rise_o(int_rise));
    edge_sync u_hs_sync (.clk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .pin_i(hs_clk_i), .rise_o(hs_rise));
    edge_sync u_sub_sync (.clk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .pin_i(sub_clk_i), .rise_o(sub_rise));

    ////////////////////////////////////////////////////////////////////////////
    // software writable bits
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            main_clock_divide_select_r <= DIV_RST;
            cpu_source_select_r <= 1'b0;
        end else if (wr_proc) begin
            cpu_source_select_r <= wdata_i[CPU_SEL_BIT];
            if (wdata_i[DIV_MSB:DIV_LSB] <= DIV_MAX) begin
                main_clock_divide_select_r <= wdata_i[DIV_MSB:DIV_LSB];
            end
        end
    end

    // main source select and the one-shot high speed enable
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            main_source_select_r <= 1'b0;
            high_speed_source_enable_r <= 1'b0;
            hs_en_lock_r <= 1'b0;
        end else if (wr_mode) begin
            main_source_select_r <= wdata_i[MAIN_SEL_BIT];
            if (!hs_en_lock_r && (wdata_i[HS_EN_BIT] != high_speed_source_enable_r)) begin
                high_speed_source_enable_r <= wdata_i[HS_EN_BIT];
                hs_en_lock_r <= 1'b1;
            end
        end
    end

    // oscillator halt bits and oscillator mode select
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            internal_osc_halt_r <= 1'b0;
            main_osc_halt_r <= MAIN_HALT_RST;
            osc_mode_r <= OSC_RST;
        end else if (ce_i && wr_i) begin
            if (addr_i == INT_OSC_IDX) begin
                internal_osc_halt_r <= wdata_i[INT_HALT_BIT];
            end
            if (addr_i == MAIN_OSC_IDX) begin
                main_osc_halt_r <= wdata_i[MAIN_HALT_BIT];
            end
            if (addr_i == OSC_IDX) begin
                osc_mode_r <= wdata_i & 8'hF3;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator run controls, halts only honoured off the running clock
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            int_osc_run_r <= 1'b1;
            main_osc_run_r <= 1'b0;
            internal_osc_state_flag_r <= 1'b0;
        end else if (ce_i) begin
            int_osc_run_r <= ~(internal_osc_halt_r &
                (main_source_status_r | cpu_source_status_r));
            main_osc_run_r <= osc_mode_r[MAINPIN_BIT] & ~(main_osc_halt_r &
                (~main_source_status_r | cpu_source_status_r));
            if (!int_osc_run_r) begin
                internal_osc_state_flag_r <= 1'b0;
            end else if (int_rise) begin
                internal_osc_state_flag_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cpu source and divider switchover
    always_comb begin
        cpu_load_val = CNT_W'(SUB_TO_MAIN_CLKS);
        if (!cpu_source_status_r && cpu_source_select_r) begin
            cpu_load_val = CNT_W'(SUB_SWITCH_EDGES);
        end else if (!cpu_source_status_r) begin
            cpu_load_val = CNT_W'(DIV_BASE_CLKS >> cpu_div_r);
        end
    end

    assign cpu_start = ce_i & (cpu_state_r == SW_IDLE) &
        ({cpu_source_select_r, main_clock_divide_select_r} !=
         {cpu_source_status_r, cpu_div_r});
    assign cpu_cnt.load = cpu_start;
    assign cpu_cnt.load_val = cpu_load_val;
    assign cpu_cnt.step = cpu_sub_step_r ? sub_rise : (ce_i & cpu_tick_i);

    // old clock keeps running until the counter finishes
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpu_state_r <= SW_IDLE;
            cpu_sub_step_r <= 1'b0;
            cpu_tgt_css_r <= 1'b0;
            cpu_tgt_div_r <= DIV_RST;
            cpu_source_status_r <= 1'b0;
            cpu_div_r <= DIV_RST;
        end else if (ce_i) begin
            case (cpu_state_r)
                SW_IDLE: begin
                    if (cpu_start) begin
                        cpu_state_r <= SW_WAIT;
                        cpu_sub_step_r <= ~cpu_source_status_r & cpu_source_select_r;
                        cpu_tgt_css_r <= cpu_source_select_r;
                        cpu_tgt_div_r <= main_clock_divide_select_r;
                    end
                end
                SW_WAIT: begin
                    if (cpu_cnt.done) begin
                        cpu_state_r <= SW_IDLE;
                        cpu_source_status_r <= cpu_tgt_css_r;
                        cpu_div_r <= cpu_tgt_div_r;
                    end
                end
                default: begin
                    cpu_state_r <= SW_IDLE;
                end
            endcase
        end
    end

    switch_counter #(.W(CNT_W)) u_cpu_cnt (.clk_i(mclk_i), .rstn_i(rstn_i),
        .ce_i(ce_i), .cnt(cpu_cnt));

    ////////////////////////////////////////////////////////////////////////////
    // main system clock source switchover on edges of the new source
    assign main_start = ce_i & ~main_cnt.busy &
        (main_source_select_r != main_source_status_r) &
        (~main_source_select_r | high_speed_source_enable_r);
    assign main_cnt.load = main_start;
    assign main_cnt.load_val = CNT_W'(MAIN_SWITCH_EDGES);
    assign main_cnt.step = main_hs_step_r ? hs_rise : int_rise;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            main_tgt_r <= 1'b0;
            main_hs_step_r <= 1'b0;
            main_source_status_r <= 1'b0;
        end else if (ce_i) begin
            if (main_start) begin
                main_tgt_r <= main_source_select_r;
                main_hs_step_r <= main_source_select_r;
            end else if (main_cnt.done) begin
                main_source_status_r <= main_tgt_r;
            end
        end
    end

    switch_counter #(.W(CNT_W)) u_main_cnt (.clk_i(mclk_i), .rstn_i(rstn_i),
        .ce_i(ce_i), .cnt(main_cnt));

    ////////////////////////////////////////////////////////////////////////////
    // cpu clock withheld after high amplitude is raised
    assign hold_start = wr_osc & wdata_i[HIGH_AMP_BIT] & ~osc_mode_r[HIGH_AMP_BIT];
    assign hold_cnt.load = hold_start;
    assign hold_cnt.load_val = wdata_i[MAINEXT_BIT] ? CNT_W'(HOLD_EXT_EDGES)
                                                    : CNT_W'(HOLD_X1_CYC);
    assign hold_cnt.step = hold_ext_r ? hs_rise : ce_i;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hold_ext_r <= 1'b0;
        end else if (hold_start) begin
            hold_ext_r <= wdata_i[MAINEXT_BIT];
        end
    end

    switch_counter #(.W(CNT_W)) u_hold_cnt (.clk_i(mclk_i), .rstn_i(rstn_i),
        .ce_i(ce_i), .cnt(hold_cnt));

    ////////////////////////////////////////////////////////////////////////////
    // register read, data one cycle after the strobe
    always_comb begin
        rd_mux = 8'h00;
        case (addr_i)
            PROC_CLK_IDX: begin
                rd_mux[DIV_MSB:DIV_LSB] = main_clock_divide_select_r;
                rd_mux[CPU_SEL_BIT] = cpu_source_select_r;
                rd_mux[CPU_STAT_BIT] = cpu_source_status_r;
            end
            MAIN_MODE_IDX: begin
                rd_mux[MAIN_SEL_BIT] = main_source_select_r;
                rd_mux[MAIN_STAT_BIT] = main_source_status_r;
                rd_mux[HS_EN_BIT] = high_speed_source_enable_r;
            end
            INT_OSC_IDX: begin
                rd_mux[INT_HALT_BIT] = internal_osc_halt_r;
                rd_mux[INT_FLAG_BIT] = internal_osc_state_flag_r;
            end
            MAIN_OSC_IDX: rd_mux[MAIN_HALT_BIT] = main_osc_halt_r;
            OSC_IDX: rd_mux = osc_mode_r;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= 8'h00;
        end else if (ce_i) begin
            rdata_r <= rd_i ? rd_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign rdata_o = rdata_r;
    assign cpu_source_status_o = cpu_source_status_r;
    assign cpu_div_o = cpu_div_r;
    assign main_source_status_o = main_source_status_r;
    assign cpu_clk_hold_o = hold_cnt.busy;
    assign int_osc_run_o = int_osc_run_r;
    assign main_osc_run_o = main_osc_run_r;
    assign sub_osc_run_o = osc_mode_r[SUBPIN_BIT];
    assign main_pin_mode_o = osc_mode_r[MAINPIN_BIT];
    assign main_external_input_mode_o = osc_mode_r[MAINEXT_BIT];
    assign sub_pin_mode_o = osc_mode_r[SUBPIN_BIT];
    assign sub_external_input_mode_o = osc_mode_r[SUBEXT_BIT];
    assign sub_osc_start_option_o = osc_mode_r[SUB_START_BIT];
    assign main_osc_high_amplitude_o = osc_mode_r[HIGH_AMP_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence main_osc_high_amplitude_rise_s;
        hold_start;
    endsequence

    sequence hold_x1_s;
        main_osc_high_amplitude_rise_s ##0 !wdata_i[MAINEXT_BIT];
    endsequence

    hold_x1_a: assert property (hold_x1_s |-> hold_cnt.load_val == 82 ##1
        cpu_clk_hold_o [*8])
        else $error("x1 hold too short or wrong length");
    hold_ext_a: assert property (main_osc_high_amplitude_rise_s ##0 wdata_i[MAINEXT_BIT]
        |-> hold_cnt.load_val == 160 ##1 cpu_clk_hold_o)
        else $error("external clock hold not started with 160 edges");
    cpu_stat_a: assert property ($changed(cpu_source_status_r) |->
        $past(cpu_cnt.done))
        else $error("cpu status changed without a finished switchover");
    main_stat_a: assert property ($changed(main_source_status_r) |->
        $past(main_cnt.done))
        else $error("main status changed without a finished switchover");
    div_count_a: assert property (cpu_start && !cpu_source_status_r &&
        !cpu_source_select_r && cpu_div_r == 3'h4 |-> cpu_cnt.load_val == 1)
        else $error("divider delay wrong for slowest divider");
    sub_main_a: assert property (cpu_start && cpu_source_status_r &&
        !cpu_source_select_r |-> cpu_cnt.load_val == 2 ##1 !cpu_sub_step_r)
        else $error("sub to main switch not two old clocks");
    hs_en_once_a: assert property (hs_en_lock_r |=> $stable(high_speed_source_enable_r))
        else $error("high speed enable changed twice");
    cpu_read_a: assert property (ce_i && rd_i && addr_i == PROC_CLK_IDX ##1 ce_i
        |-> rdata_o[CPU_STAT_BIT] == $past(cpu_source_status_r) && rdata_o[7:6] == 2'b00)
        else $error("cpu status readback wrong");
    sub_stop_a: assert property ($fell(osc_mode_r[SUBPIN_BIT]) |-> !sub_osc_run_o)
        else $error("subsystem clock not stopped");
    int_halt_a: assert property (ce_i && internal_osc_halt_r && cpu_source_status_r
        |=> !int_osc_run_o)
        else $error("internal oscillator not halted");
endmodule : cpu_clock_switchover_control

// ===== dv/tb.sv
// self-checking bench for the cpu clock switchover control
`timescale 1ns/10ps
module tb;
    import clk_switch_pkg::*;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic tick_r = 1'b0;
    logic [1:0] pin_r = 2'h0; // bit 0 high-speed pin, bit 1 sub clock pin
    logic [7:0] rdata_o;
    logic cpu_status, main_status, hold, int_run, main_run, sub_pin;
    logic [2:0] div;
    int bad_count = 0;
    int tests_run = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // device under test, clock enable and internal oscillator pin tied off
    cpu_clock_switchover_control dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cpu_tick_i(tick_r), .int_osc_clk_i(1'b0), .hs_clk_i(pin_r[0]), .sub_clk_i(pin_r[1]),
        .cpu_source_status_o(cpu_status), .cpu_div_o(div), .main_source_status_o(main_status),
        .cpu_clk_hold_o(hold), .int_osc_run_o(int_run), .main_osc_run_o(main_run),
        .sub_osc_run_o(), .main_pin_mode_o(), .main_external_input_mode_o(),
        .sub_pin_mode_o(sub_pin), .sub_external_input_mode_o(), .sub_osc_start_option_o(),
        .main_osc_high_amplitude_o());

    // 20 MHz clock
    always #25 mclk_i = ~mclk_i;

    ////////////////////////////////////////////////////////////////////////////////
    // shared bus, pin and compare tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run;
        if (bad_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    // read strobe for one cycle, data judged in the following cycle
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : idle

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge mclk_i) tick_r <= 1'b1;
            @(posedge mclk_i) tick_r <= 1'b0;
        end
    endtask : ticks

    // slow pin rises, long enough for the two-flop synchroniser
    task automatic rises(input int which, input int n);
        repeat (n) begin
            @(posedge mclk_i) pin_r[which] <= 1'b1;
            repeat (4) @(posedge mclk_i);
            pin_r[which] <= 1'b0;
            repeat (4) @(posedge mclk_i);
        end
        #1;
    endtask : rises

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        rd(PROC_CLK_IDX, 8'h00);
        rd(MAIN_MODE_IDX, 8'h00);
        rd(INT_OSC_IDX, 8'h00);
        rd(MAIN_OSC_IDX, 8'h80);
        rd(3'h5, 8'h00);
        wr(MAIN_OSC_IDX, 8'h80);
        wr(INT_OSC_IDX, 8'h01);
        idle(2);
        chk(int_run, 1'b1);
        wr(INT_OSC_IDX, 8'h00);
    endtask : t_reset

    task automatic t_div;
        for (int d = 0; d < 4; d++) begin
            wr(PROC_CLK_IDX, 8'(d + 1));
            idle(3);
            ticks((16 >> d) - 1);
            idle(2);
            chk(div, 8'(d));
            ticks(1);
            idle(2);
            chk(div, 8'(d + 1));
        end
        // slowest divider back to undivided takes one old clock
        wr(PROC_CLK_IDX, 8'h00);
        idle(3);
        ticks(1);
        idle(2);
        chk(div, 8'h00);
    endtask : t_div

    // crystal subclock first, then external subclock input
    task automatic t_sub;
        for (int m = 0; m < 2; m++) begin
            wr(OSC_IDX, (m == 0) ? 8'h10 : 8'h30);
            wr(PROC_CLK_IDX, 8'h10);
            idle(3);
            rises(1, 1);
            chk(cpu_status, 1'b0);
            rises(1, 1);
            chk(cpu_status, 1'b1);
            rd(PROC_CLK_IDX, 8'h30);
            wr(INT_OSC_IDX, 8'h01);
            idle(2);
            chk(int_run, 1'b0);
            wr(INT_OSC_IDX, 8'h00);
            wr(PROC_CLK_IDX, 8'h00);
            idle(3);
            ticks(1);
            idle(2);
            chk(cpu_status, 1'b1);
            ticks(1);
            idle(2);
            chk({cpu_status, div}, 8'h00);
            wr(OSC_IDX, 8'h00);
            idle(2);
            chk(sub_pin, 1'b0);
        end
    endtask : t_sub

    task automatic t_main;
        wr(MAIN_MODE_IDX, 8'h01);
        rises(0, 3);
        chk(main_status, 1'b0);
        wr(MAIN_MODE_IDX, 8'h05);
        idle(2);
        rises(0, 1);
        chk(main_status, 1'b0);
        rises(0, 1);
        chk(main_status, 1'b1);
        rd(MAIN_MODE_IDX, 8'h07);
        wr(MAIN_MODE_IDX, 8'h01);
        rd(MAIN_MODE_IDX, 8'h07);
    endtask : t_main

    task automatic t_hold;
        int n;
        n = 0;
        wr(OSC_IDX, 8'h40);
        wr(OSC_IDX, 8'h41);
        // hold rises on the write edge itself, so look before each next edge
        for (int i = 0; i < 400; i++) begin
            #1;
            if (hold === 1'b1) n++;
            else if (n > 0) break;
            @(posedge mclk_i);
        end
        if (hold !== 1'b0) begin
            bad_count++;
            complete_run();
        end
        chk(n >= 82 && n <= 322, 1'b1);
        chk(main_run, 1'b1);
        wr(OSC_IDX, 8'hc0);
        wr(OSC_IDX, 8'hc1);
        rises(0, 159);
        chk(hold, 1'b1);
        rises(0, 1);
        chk(hold, 1'b0);
    endtask : t_hold

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: reset for 20 cycles, then each scenario in turn
    initial begin
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1'b1;
        t_reset();
        t_div();
        t_sub();
        t_main();
        t_hold();
        complete_run();
    end
endmodule : tb
